// ### shared/retry_pkg.sv
// Purpose: shared constants, tables and state type of the fault retry and warning logic
// Assumes: 40 MHz system clock, millisecond base tick for all long timers
// Notes: field decode tables are indexed by the three-bit configuration fields

package retry_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int TIMER_W = 16;

  // ==========================================================================
  // field decode tables
  localparam int FIELD_W = 3;
  localparam int FIELD_N = 8;
  localparam int RETRY_W = 6;
  localparam logic [RETRY_W-1:0] RETRY_LIMIT [FIELD_N] = '{
    6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
  localparam logic [TIMER_W-1:0] COOLDOWN_MS [FIELD_N] = '{
    16'h0000, 16'(1 * MS_PER_S), 16'(2 * MS_PER_S), 16'(4 * MS_PER_S),
    16'(8 * MS_PER_S), 16'(16 * MS_PER_S), 16'(32 * MS_PER_S), 16'(64 * MS_PER_S)};
  localparam logic [TIMER_W-1:0] DEGLITCH_MS [FIELD_N] = '{
    16'h0000, 16'h000A, 16'h0014, 16'h0032, 16'h0064, 16'h00C8, 16'h01F4, 16'h03E8};

  // ==========================================================================
  // retry-class fault bits and fault status layout
  localparam int RETRY_FAULTS = 5;
  localparam int F_OUTPUT_UNDERVOLTAGE = 0;
  localparam int F_POWERUP_WATCHDOG = 1;
  localparam int F_OVERCURRENT = 2;
  localparam int F_SAFE_AREA_REGULATION = 3;
  localparam int F_SEVERE_OVERCURRENT = 4;
  localparam int F_UNSUCCESSFUL_RETRY = 5;
  localparam int F_MEMORY = 6;
  localparam int F_SWITCH_SHORT = 7;
  localparam int FAULT_W = 8;
  localparam logic [RETRY_FAULTS-1:0] SOC_ONLY = 5'h10;
  localparam logic [FAULT_W-1:0] FAULT_CLEAR = 8'h00;

  // ==========================================================================
  // warning bits
  localparam int W_GATE_VOLTAGE_LOW = 0;
  localparam int W_EXTERNAL_OVERTEMPERATURE = 1;
  localparam int W_DIE_THERMAL_SHUTDOWN = 2;
  localparam int W_INPUT_UNDERVOLTAGE = 3;
  localparam int W_INPUT_OVERVOLTAGE = 4;
  localparam int W_OUTPUT_OVERVOLTAGE = 5;
  localparam int W_OUTPUT_UNDERVOLTAGE = 6;
  localparam int W_SAFE_AREA_REGULATION = 7;
  localparam int W_OUTPUT_UNDERCURRENT = 8;
  localparam int W_OUTPUT_OVERCURRENT_WARNING = 9;
  localparam int W_NEGATIVE_CURRENT = 10;
  localparam int W_INPUT_OVERPOWER = 11;
  localparam int W_COMMUNICATION_WARNING = 12;
  localparam int WARN_N = 13;

  // ==========================================================================
  // controller states
  typedef enum logic [3:0] {
    por_init_state,
    switch_check_state,
    standby_state,
    initial_safe_area_regulation_state,
    on_state,
    current_regulation_state,
    fault_state,
    latch_off_state,
    memory_fault_state
  } ctrl_state_t;

endpackage

// ### verilog/ms_timer.sv
// Purpose: down-counting timer on a slow tick, with load, cancel and a done pulse
// Assumes: tick_i is a one-cycle enable pulse
// Notes: a load with count zero gives done on the next cycle

`timescale 1ns/10ps

module ms_timer #(
  parameter int W = retry_pkg::TIMER_W
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic cancel_i,
  input wire logic [W-1:0] count_i,
  output logic busy_o,
  output logic done_o
);
  import retry_pkg::*;

  logic [W-1:0] remaining;

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || cancel_i) begin
      remaining <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (load_i) begin
      remaining <= count_i;
      busy_o <= (count_i != '0);
      done_o <= (count_i == '0);
    end else if (busy_o && tick_i) begin
      remaining <= remaining - W'(1);
      busy_o <= (remaining != W'(1));
      done_o <= (remaining == W'(1));
    end else begin
      done_o <= 1'b0;
    end
  end

endmodule

// ### verilog/fault_retry_latchoff_warning_logic.sv
// Purpose: retry, cool-down, latch-off and sticky warning control of a hot-swap controller
// Assumes: fault and warning conditions arrive already detected, synchronous to sys_clk_i
// Notes: open-drain pins appear as a value and an active-low output enable
//
// How it works
// - only the five retry-class faults lead to an automatic re-attempt
// - three-bit field sets 0 to 32 attempts; zero latches off at first fault unless all masks are zero
// - counter disabled means unlimited re-attempts
// - cool-down of 0 to 64 s from a three-bit field precedes each re-attempt
// - during cool-down stay in fault, ignore clear command and enable toggling
// - per-fault mask bit turns the cool-down on or off for that fault
// - count field and masks all zero: unlimited re-attempts, no cool-down
// - retry-OK deglitch timer starts on entering on state after a re-attempt
// - deglitch expiry with no fault reloads the attempt counter
// - attempts exhausted raises unsuccessful-retry fault and latches off
// - fast-recovery enable skips cool-down after a severe overcurrent
// - fast recovery with low drain-source voltage enables strong gate pull-up
// - fast-recovery attempts are bounded by the attempt counter too
// - latch-off keeps switch off and freezes pins and status, except the memory-fault and communication-warning bits
// - memory fault or switch short latches off immediately
// - power cycle leaves latch-off and restarts from power-on init
// - clear command or enable falling edge leaves ordinary latch-off only
// - that exit releases pins, clears status, continues at switch check
// - warnings never stop the switch; only enabled warnings set status
// - warning pin of chosen polarity and alert summary from masked bits
// - warning status is sticky until clear, restart or power cycle
// - each warning is evaluated only in its listed operating states
// - each re-attempt decrements the counter unless re-attempts are unlimited; a fault at zero raises unsuccessful retry

`timescale 1ns/10ps

module fault_retry_latchoff_warning_logic #(
  parameter int TICK_CYCLES = retry_pkg::TICK_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [retry_pkg::FIELD_W-1:0] retry_counter_field_i,
  input wire logic retry_counter_disable_i,
  input wire logic [retry_pkg::FIELD_W-1:0] cooldown_time_field_i,
  input wire logic [retry_pkg::FIELD_W-1:0] retry_ok_deglitch_field_i,
  input wire logic [retry_pkg::RETRY_FAULTS-1:0] retry_mask_i,
  input wire logic gate_fast_recovery_enable_i,
  input wire logic clear_faults_i,
  input wire logic controller_restart_i,
  input wire logic enable_pin_i,
  input wire logic enable_is_pin_cfg_i,
  input wire logic [retry_pkg::RETRY_FAULTS-1:0] retry_fault_event_i,
  input wire logic mem_fault_i,
  input wire logic switch_short_i,
  input wire logic switch_check_ok_i,
  input wire logic power_request_i,
  input wire logic fully_enhanced_i,
  input wire logic regulating_i,
  input wire logic vds_low_i,
  input wire logic [retry_pkg::WARN_N-1:0] warning_enable_i,
  input wire logic [retry_pkg::WARN_N-1:0] warning_condition_i,
  input wire logic [retry_pkg::WARN_N-1:0] warning_mask_i,
  input wire logic [retry_pkg::FAULT_W-1:0] fault_alert_mask_i,
  input wire logic warning_polarity_high_i,
  input wire logic [1:0] alert_source_i,
  output logic switch_on_o,
  output logic strong_pullup_o,
  output logic power_good_pin_o,
  output logic fault_pin_o,
  output logic warning_output_pin_o,
  output logic warning_output_pin_oe_n_o,
  output logic alert_pin_o,
  output logic alert_pin_oe_n_o,
  output logic [retry_pkg::FAULT_W-1:0] fault_status_o,
  output logic [retry_pkg::WARN_N-1:0] warning_status_o,
  output logic [retry_pkg::RETRY_W-1:0] retries_left_o,
  output logic cooldown_active_o
);
  import retry_pkg::*;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ==========================================================================
  // operating-state activity of each warning
  function automatic logic warn_active(input ctrl_state_t st, input int idx);
    logic std_set;
    logic run_set;
    std_set = (st == standby_state) || (st == initial_safe_area_regulation_state) || (st == on_state) ||
              (st == current_regulation_state) || (st == fault_state);
    run_set = (st == on_state) || (st == current_regulation_state);
    case (idx)
      W_GATE_VOLTAGE_LOW: warn_active = (st == on_state);
      W_EXTERNAL_OVERTEMPERATURE, W_DIE_THERMAL_SHUTDOWN, W_INPUT_UNDERVOLTAGE,
      W_INPUT_OVERVOLTAGE, W_OUTPUT_OVERVOLTAGE: warn_active = std_set;
      W_INPUT_OVERPOWER: warn_active = run_set || (st == initial_safe_area_regulation_state);
      W_COMMUNICATION_WARNING: warn_active = std_set || (st == latch_off_state) || (st == memory_fault_state);
      default: warn_active = run_set;
    endcase
  endfunction

  ctrl_state_t state;
  logic [TICK_W-1:0] tick_cnt;
  logic tick;
  logic enable_prev;
  logic latch_prev;
  logic retried;
  logic cd_busy;
  logic cd_done;
  logic dg_done;

  // ==========================================================================
  // decisions
  logic in_run;
  logic in_latch;
  logic fault_hit;
  logic no_limit;
  logic exhausted;
  logic cd_need;
  logic en_fall;
  logic clear_ok;
  logic leave_latch;
  logic enter_soa;
  logic enter_on;
  logic quiet;
  logic [RETRY_FAULTS-1:0] soc_skip;
  logic warn_any;
  logic [RETRY_W-1:0] limit;

  assign limit = RETRY_LIMIT[retry_counter_field_i];
  assign in_run = (state == initial_safe_area_regulation_state) || (state == on_state) ||
                  (state == current_regulation_state);
  assign in_latch = (state == latch_off_state) || (state == memory_fault_state);
  assign fault_hit = in_run && (retry_fault_event_i != '0);
  assign no_limit = retry_counter_disable_i || ((limit == '0) && (retry_mask_i == '0));
  assign exhausted = !no_limit && (retries_left_o == '0);
  assign soc_skip = gate_fast_recovery_enable_i ? SOC_ONLY : '0;
  assign cd_need = (retry_fault_event_i & retry_mask_i & ~soc_skip) != '0;
  assign en_fall = enable_is_pin_cfg_i && enable_prev && !enable_pin_i;
  assign clear_ok = clear_faults_i && (state != fault_state);
  assign leave_latch = (state == latch_off_state) && (clear_faults_i || en_fall);
  assign enter_soa = (state == standby_state) && power_request_i;
  assign enter_on = (state == initial_safe_area_regulation_state) && fully_enhanced_i && !fault_hit;
  assign quiet = !controller_restart_i && !mem_fault_i && !switch_short_i;
  assign warn_any = (warning_status_o & warning_mask_i) != '0;

  // ==========================================================================
  // millisecond tick
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tick <= 1'b0;
      enable_prev <= 1'b0;
      latch_prev <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_W'(TICK_CYCLES - 1));
      enable_prev <= enable_pin_i;
      latch_prev <= in_latch;
    end
  end

  ms_timer #(.W(TIMER_W)) cooldown_timer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick),
    .load_i(fault_hit && !exhausted),
    .cancel_i(controller_restart_i),
    .count_i(cd_need ? COOLDOWN_MS[cooldown_time_field_i] : '0),
    .busy_o(cd_busy),
    .done_o(cd_done)
  );

  ms_timer #(.W(TIMER_W)) deglitch_timer (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick),
    .load_i(enter_on && retried),
    .cancel_i(fault_hit || controller_restart_i),
    .count_i(DEGLITCH_MS[retry_ok_deglitch_field_i]),
    .busy_o(),
    .done_o(dg_done)
  );

  // ==========================================================================
  // controller state
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || controller_restart_i) begin
      state <= por_init_state;
    end else if (mem_fault_i && state != memory_fault_state) begin
      state <= memory_fault_state;
    end else if (switch_short_i && !in_latch) begin
      state <= latch_off_state;
    end else if (fault_hit) begin
      state <= exhausted ? latch_off_state : fault_state;
    end else begin
      case (state)
        por_init_state: state <= switch_check_state;
        switch_check_state: if (switch_check_ok_i) state <= standby_state;
        standby_state: if (power_request_i) state <= initial_safe_area_regulation_state;
        initial_safe_area_regulation_state: if (fully_enhanced_i) state <= on_state;
        on_state: if (regulating_i) state <= current_regulation_state;
        current_regulation_state: if (!regulating_i) state <= on_state;
        fault_state: if (cd_done) state <= standby_state;
        latch_off_state: if (leave_latch) state <= switch_check_state;
        memory_fault_state: state <= memory_fault_state;
        default: state <= por_init_state;
      endcase
    end
  end

  // ==========================================================================
  // attempt counter
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      retries_left_o <= '0;
      retried <= 1'b0;
    end else if (fault_hit) begin
      retried <= !exhausted;
      if (!exhausted && !no_limit) retries_left_o <= retries_left_o - RETRY_W'(1);
    end else if (state == por_init_state || leave_latch || dg_done) begin
      retries_left_o <= limit;
      retried <= 1'b0;
    end
  end

  // ==========================================================================
  // switch drive; warnings have no path to it
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      switch_on_o <= 1'b0;
      strong_pullup_o <= 1'b0;
      cooldown_active_o <= 1'b0;
    end else begin
      switch_on_o <= (in_run || enter_soa) && !fault_hit && quiet;
      cooldown_active_o <= cd_busy;
      if (enter_soa && quiet) begin
        strong_pullup_o <= gate_fast_recovery_enable_i && vds_low_i;
      end else if (state != initial_safe_area_regulation_state || fully_enhanced_i || fault_hit || !quiet) begin
        strong_pullup_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // fault status, frozen while latched off except for the memory-fault bit
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || controller_restart_i) begin
      fault_status_o <= FAULT_CLEAR;
    end else if (in_latch) begin
      if (leave_latch) fault_status_o <= FAULT_CLEAR;
      if (mem_fault_i) fault_status_o[F_MEMORY] <= 1'b1;
    end else begin
      fault_status_o <= (clear_ok ? FAULT_CLEAR : fault_status_o) |
        {switch_short_i, mem_fault_i, fault_hit && exhausted,
         in_run ? retry_fault_event_i : RETRY_FAULTS'(0)};
    end
  end

  // ==========================================================================
  // sticky warning status
  genvar gi;
  generate
    for (gi = 0; gi < WARN_N; gi++) begin : g_warn
      logic set_w;
      assign set_w = warning_enable_i[gi] && warning_condition_i[gi] && warn_active(state, gi);
      always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i || controller_restart_i) begin
          warning_status_o[gi] <= 1'b0;
        end else if (in_latch && gi != W_COMMUNICATION_WARNING) begin
          if (leave_latch) warning_status_o[gi] <= 1'b0;
        end else begin
          warning_status_o[gi] <= ((clear_ok || leave_latch) ? 1'b0 : warning_status_o[gi]) | set_w;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // status pins; one update on the first latched cycle, then frozen
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i || leave_latch) begin
      power_good_pin_o <= 1'b0;
      fault_pin_o <= 1'b0;
      warning_output_pin_o <= 1'b0;
      warning_output_pin_oe_n_o <= 1'b1;
      alert_pin_o <= 1'b0;
      alert_pin_oe_n_o <= 1'b1;
    end else if (!(in_latch && latch_prev)) begin
      power_good_pin_o <= (state == on_state) || (state == current_regulation_state);
      fault_pin_o <= fault_status_o != FAULT_CLEAR;
      warning_output_pin_oe_n_o <= warning_polarity_high_i ? warn_any : !warn_any;
      alert_pin_oe_n_o <= !((alert_source_i[0] && (fault_status_o & fault_alert_mask_i) != FAULT_CLEAR) ||
                            (alert_source_i[1] && warn_any));
    end
  end

  // ==========================================================================
  // checks
  latch_switch_off_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_latch |-> !switch_on_o) else $error("switch on while latched off");

  ur_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    fault_hit && exhausted && quiet |=> state == latch_off_state && fault_status_o[F_UNSUCCESSFUL_RETRY])
    else $error("exhausted attempts did not latch off");

  init_load_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == por_init_state |=> retries_left_o == RETRY_LIMIT[$past(retry_counter_field_i)])
    else $error("attempt counter not loaded from field");

  decrement_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    fault_hit && !exhausted && !no_limit |=> retries_left_o == $past(retries_left_o) - RETRY_W'(1))
    else $error("attempt counter not decremented");

  unlimited_retry_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    fault_hit && no_limit && quiet |=> state == fault_state) else $error("unlimited retry latched off");

  cooldown_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == fault_state && cd_busy && (clear_faults_i || en_fall) && quiet |=>
      state == fault_state && $stable(fault_status_o)) else $error("cool-down left on clear or enable");

  skip_cooldown_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    fault_hit && !exhausted && !cd_need && quiet ##1 quiet |=> state == standby_state)
    else $error("cool-down not skipped");

  soc_fast_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    fault_hit && !exhausted && gate_fast_recovery_enable_i && retry_fault_event_i == SOC_ONLY && quiet
      ##1 quiet |=> state == standby_state) else $error("fast recovery waited for cool-down");

  pullup_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    enter_soa && gate_fast_recovery_enable_i && vds_low_i && quiet |=>
      strong_pullup_o && state == initial_safe_area_regulation_state) else $error("strong pull-up missing");

  pin_freeze_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    in_latch && latch_prev && !leave_latch && !controller_restart_i |=>
      $stable(fault_pin_o) && $stable(power_good_pin_o) && $stable(fault_status_o))
    else $error("status moved while latched off");

  leave_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    leave_latch && quiet |=> state == switch_check_state && fault_status_o == FAULT_CLEAR && !fault_pin_o)
    else $error("latch-off exit incomplete");

  mem_stays_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    state == memory_fault_state && !controller_restart_i |=> state == memory_fault_state)
    else $error("memory fault state left");

  mem_latch_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mem_fault_i && !controller_restart_i |=> state == memory_fault_state) else $error("memory fault not latched");

  gate_warn_gate_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    !warning_status_o[W_GATE_VOLTAGE_LOW] && state != on_state |=> !warning_status_o[W_GATE_VOLTAGE_LOW])
    else $error("gate warning set outside on state");

  reload_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    dg_done && !fault_hit && !leave_latch && state != por_init_state |=> retries_left_o == $past(limit))
    else $error("attempt counter not restored");

  ur_cover: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) fault_hit && exhausted);
  exit_cover: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) leave_latch);
  retry_cover: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) state == fault_state && cd_done);
  reload_cover: cover property (@(posedge sys_clk_i) disable iff (sys_rst_i) dg_done);

endmodule

// ### verification/host_model.sv
// Purpose: host side model issuing clear commands, enable pin levels and retry masks
// Assumes: bench requests are levels set at the falling edge
// Notes: clear is a one-cycle pulse, watchdog mask bit is set whenever any mask is used
`timescale 1ns/10ps
module host_model (
  input wire logic clk_i,
  input wire logic clear_req_i,
  input wire logic enable_req_i,
  input wire logic [4:0] mask_req_i,
  output logic clear_o,
  output logic enable_o,
  output logic [4:0] mask_o
);
  initial begin
    clear_o = 1'h0;
    enable_o = 1'h1;
  end
  always @(negedge clk_i) begin
    clear_o <= clear_req_i & ~clear_o;
    enable_o <= enable_req_i;
  end
  assign mask_o = (mask_req_i != 5'h00) ? (mask_req_i | 5'h02) : 5'h00;
endmodule

// ### verification/testbench.sv
// Purpose: self-checking bench of the retry, latch-off and warning logic
// Assumes: short tick parameter, inputs driven at the falling edge
// Notes: expected values come from integer bookkeeping in the bench
`timescale 1ns/10ps
module testbench;
  import retry_pkg::*;
  localparam int TICKS = 4;
  logic sys_clk_i = 1'h0, sys_rst_i = 1'h1, retry_counter_disable_i = 1'h0, gate_fast_recovery_enable_i = 1'h0;
  logic controller_restart_i = 1'h0, enable_is_pin_cfg_i = 1'h1, mem_fault_i = 1'h0, switch_short_i = 1'h0;
  logic switch_check_ok_i = 1'h0, power_request_i = 1'h0, fully_enhanced_i = 1'h0, regulating_i = 1'h0;
  logic vds_low_i = 1'h0, warning_polarity_high_i = 1'h0, clear_faults_i, enable_pin_i, clr_req = 1'h0, en_req = 1'h1;
  logic [2:0] retry_counter_field_i = 3'h2, cooldown_time_field_i = 3'h0, retry_ok_deglitch_field_i = 3'h0;
  logic [4:0] retry_mask_i, retry_fault_event_i = 5'h00, mask_req = 5'h00;
  logic [12:0] warning_enable_i = 13'h0000, warning_condition_i = 13'h0000, warning_mask_i = 13'h1FFF;
  logic [7:0] fault_alert_mask_i = 8'hFF;
  logic [1:0] alert_source_i = 2'h2;
  logic switch_on_o, strong_pullup_o, power_good_pin_o, fault_pin_o, warning_output_pin_o, warning_output_pin_oe_n_o;
  logic alert_pin_o, alert_pin_oe_n_o, cooldown_active_o;
  logic [7:0] fault_status_o;
  logic [12:0] warning_status_o;
  logic [5:0] retries_left_o;
  int mismatches = 0, cmp_count = 0, cycles = 0, n, exp_warn;
  fault_retry_latchoff_warning_logic #(.TICK_CYCLES(TICKS)) fault_retry_latchoff_warning_logic_i (.sys_clk_i,
    .sys_rst_i, .retry_counter_field_i, .retry_counter_disable_i, .cooldown_time_field_i, .retry_ok_deglitch_field_i,
    .retry_mask_i, .gate_fast_recovery_enable_i, .clear_faults_i, .controller_restart_i, .enable_pin_i,
    .enable_is_pin_cfg_i, .retry_fault_event_i, .mem_fault_i, .switch_short_i, .switch_check_ok_i, .power_request_i,
    .fully_enhanced_i, .regulating_i, .vds_low_i, .warning_enable_i, .warning_condition_i, .warning_mask_i,
    .fault_alert_mask_i, .warning_polarity_high_i, .alert_source_i, .switch_on_o, .strong_pullup_o, .power_good_pin_o,
    .fault_pin_o, .warning_output_pin_o, .warning_output_pin_oe_n_o, .alert_pin_o, .alert_pin_oe_n_o, .fault_status_o,
    .warning_status_o, .retries_left_o, .cooldown_active_o);
  host_model host_model_i (.clk_i(sys_clk_i), .clear_req_i(clr_req), .enable_req_i(en_req), .mask_req_i(mask_req),
    .clear_o(clear_faults_i), .enable_o(enable_pin_i), .mask_o(retry_mask_i));
  always #12.5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk_i);
  endtask
  task automatic fault(input int b);
    retry_fault_event_i <= 5'h01 << b;
    cyc(1);
    retry_fault_event_i <= 5'h00;
  endtask
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    n = $urandom(32'h03A0AC89);
    cyc(5);
    chk("rst_warn_oe_n", warning_output_pin_oe_n_o, 1'h1);
    sys_rst_i <= 1'h0;
    switch_check_ok_i <= 1'h1;
    power_request_i <= 1'h1;
    fully_enhanced_i <= 1'h1;
    cyc(8);
    chk("on", switch_on_o, 1'h1);
    chk("retries", retries_left_o, 16'(RETRY_LIMIT[2]));
    warning_enable_i <= 13'($urandom) | 13'h0001;
    warning_condition_i <= 13'($urandom);
    cyc(1);
    exp_warn = int'(warning_condition_i & warning_enable_i);
    warning_condition_i <= 13'h0000;
    cyc(4);
    chk("warn_status", warning_status_o, 16'(exp_warn));
    chk("alert", alert_pin_oe_n_o, 1'(exp_warn == 0));
    chk("warn_pin", {warning_output_pin_oe_n_o, warning_output_pin_o, alert_pin_o}, {1'(exp_warn == 0), 2'h0});
    chk("on_warn", switch_on_o, 1'h1);
    fault(0);
    chk("retries_dec", retries_left_o, 16'(RETRY_LIMIT[2] - 1));
    chk("fault_bit", fault_status_o[0], 1'h1);
    chk("no_cool", cooldown_active_o, 1'h0);
    cyc(8);
    chk("reload", retries_left_o, 16'(RETRY_LIMIT[2]));
    cooldown_time_field_i <= 3'h1;
    mask_req <= 5'h14;
    fault(2);
    cyc(1);
    chk("cool", cooldown_active_o, 1'h1);
    clr_req <= 1'h1;
    cyc(1);
    clr_req <= 1'h0;
    cyc(3);
    chk("held", fault_status_o[2], 1'h1);
    for (n = 5; cooldown_active_o === 1'h1 && n < 5000; n++) cyc(1);
    chk("cool_len", 1'(n >= 1000 * TICKS - 10 && n <= 1000 * TICKS + 10), 1'h1);
    cyc(8);
    chk("retried", switch_on_o, 1'h1);
    gate_fast_recovery_enable_i <= 1'h1;
    fault(4);
    cyc(1);
    chk("fast", cooldown_active_o, 1'h0);
    retry_counter_field_i <= 3'h0;
    controller_restart_i <= 1'h1;
    fully_enhanced_i <= 1'h0;
    vds_low_i <= 1'h1;
    cyc(1);
    controller_restart_i <= 1'h0;
    cyc(8);
    chk("restart_warn", warning_status_o, 16'h0000);
    chk("pullup", strong_pullup_o, 1'h1);
    warning_condition_i <= 13'h1FFF;
    cyc(2);
    chk("soa_warn", warning_status_o, 16'(warning_enable_i & 13'h183E));
    warning_condition_i <= 13'h0000;
    fully_enhanced_i <= 1'h1;
    clr_req <= 1'h1;
    cyc(1);
    clr_req <= 1'h0;
    cyc(8);
    chk("clear_warn", warning_status_o, 16'h0000);
    chk("pullup_off", strong_pullup_o, 1'h0);
    for (int m = 0; m < 2; m++) begin
      fault(3 + m);
      chk("latched", fault_status_o[5], 1'h1);
      warning_condition_i <= 13'h0FFF;
      cyc(3);
      chk("frozen", warning_status_o, 16'h0000);
      chk("off", switch_on_o, 1'h0);
      chk("fault_pin", fault_pin_o, 1'h1);
      warning_condition_i <= 13'h0000;
      if (m == 0) en_req <= 1'h0;
      else clr_req <= 1'h1;
      cyc(1);
      clr_req <= 1'h0;
      en_req <= 1'h1;
      cyc(3);
      chk("exit", fault_status_o, 16'h0000);
      chk("exit_pin", fault_pin_o, 1'h0);
      cyc(8);
      chk("resume", switch_on_o, 1'h1);
      chk("resume_pg", power_good_pin_o, 1'h1);
    end
    for (int m = 0; m < 2; m++) begin
      retry_counter_disable_i <= 1'(m);
      mask_req <= m ? 5'h14 : 5'h00;
      fault(0);
      chk("no_ur", fault_status_o[5], 1'h0);
      cyc(8);
      chk("unlimited", switch_on_o, 1'h1);
    end
    mem_fault_i <= 1'h1;
    cyc(1);
    mem_fault_i <= 1'h0;
    clr_req <= 1'h1;
    cyc(1);
    clr_req <= 1'h0;
    cyc(3);
    chk("mem", fault_status_o[6], 1'h1);
    chk("mem_off", switch_on_o, 1'h0);
    sys_rst_i <= 1'h1;
    cyc(2);
    sys_rst_i <= 1'h0;
    cyc(2);
    chk("power_cycle", fault_status_o, 16'h0000);
    finish_test();
  end
endmodule
